/* ipc_pkg.sv */
`default_nettype none
package ipc_pkg;
  localparam logic [7:0] IPC_OFF_STATUS    = 8'h00;
  localparam logic [7:0] IPC_OFF_CTRL1     = 8'h04;
  localparam logic [7:0] IPC_OFF_CTRL2     = 8'h08;
  localparam logic [7:0] IPC_OFF_BUF       = 8'h0C;
  localparam logic [7:0] IPC_OFF_RELOAD    = 8'h10;
  localparam logic [7:0] IPC_OFF_EVENT     = 8'h14;
  localparam logic [7:0] IPC_REG_RST       = 8'h00;
  localparam logic [3:0] IPC_MODE_MASTER   = 4'h8;
  localparam logic [3:0] IPC_MODE_SLV7     = 4'h6;
  localparam logic [3:0] IPC_MODE_SLV10    = 4'h7;
  localparam logic [3:0] IPC_MODE_SLV7_SS  = 4'hE;
  localparam logic [3:0] IPC_MODE_SLV10_SS = 4'hF;
  localparam logic [3:0] IPC_BIT_ACK       = 4'h8;
  localparam logic [3:0] IPC_BIT_LAST_RX   = 4'h7;
  localparam logic [3:0] IPC_BIT_END       = 4'h9;
  localparam logic [2:0] IPC_SYNC_RST      = 3'h7;

  typedef struct packed {
    logic slew_control_off;
    logic smbus_select;
    logic data_not_addr;
    logic stop_seen;
    logic start_seen;
    logic read_dir;
    logic renew_addr_flag;
    logic buffer_loaded;
  } ipc_status_t;

  typedef struct packed {
    logic       write_clash_flag;
    logic       receive_overrun_flag;
    logic       port_enable;
    logic       clock_release;
    logic [3:0] port_mode_select;
  } ipc_ctrl1_t;

  typedef struct packed {
    logic general_call_enable;
    logic peer_ack_flag;
    logic ack_value_to_send;
    logic ack_sequence_trigger;
    logic receive_trigger;
    logic stop_cond_trigger;
    logic restart_trigger;
    logic begin_cond_trigger;
  } ipc_ctrl2_t;

  typedef enum logic [2:0] {
    MS_IDLE    = 3'b000,
    MS_START   = 3'b001,
    MS_RESTART = 3'b010,
    MS_STOP    = 3'b011,
    MS_TX      = 3'b100,
    MS_RX      = 3'b101,
    MS_ACK     = 3'b110
  } ipc_mstate_t;
endpackage
`default_nettype wire

/* ipc_port.sv */
`default_nettype none
module ipc_port
  import ipc_pkg::*;
#(
  parameter int ADR_W = 8
)(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  output logic                  pins_to_port,
  output logic                  slew_control_off,
  output logic                  smbus_levels,
  output logic                  port_interrupt_flag
);
  ipc_status_t st, next_st;
  ipc_ctrl1_t  c1, next_c1;
  ipc_ctrl2_t  c2, next_c2;
  ipc_mstate_t ms, next_ms;
  logic [7:0]  serial_buffer, next_buf;
  logic [7:0]  address_reload, next_reload;
  logic [7:0]  serial_shifter, next_shift;
  logic        next_irq;
  logic [1:0]  m_phase, next_phase;
  logic [3:0]  m_bit, next_bit;
  logic [6:0]  m_baud, next_baud;
  logic        m_scl_low, next_mscl;
  logic        m_sda_low, next_msda;
  logic [3:0]  s_bits, next_sbits;
  logic        s_addressed, next_saddr;
  logic        s_addr_phase, next_saddrph;
  logic        s_tx, next_stx;
  logic        s_ack_pend, next_sackp;
  logic        s_sda_low, next_ssda;
  logic        next_ack;
  logic [31:0] next_dat;
  logic [2:0]  sync_q [2];
  logic        line [2];
  logic        scl_prev, sda_prev;
  logic        req, wr, rd, en, master_hw, slave_mode;
  logic        port_busy, buf_blocked, tick, m_done, is_bit, bitval;
  logic        scl_rise, scl_fall, start_ev, stop_ev, match;
  logic [4:0]  trig;
  logic [3:0]  last_bit;
  logic [2:0]  tx_idx;

  // Pin synchronisers, scl then sda
  for (genvar i = 0; i < 2; i++)
  begin : g_sync
    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        sync_q[i] <= IPC_SYNC_RST;
        line[i]   <= 1'b1;
      end
      else
      begin
        sync_q[i] <= {sync_q[i][1:0], (i == 0) ? scl_i : sda_i};
        if (sync_q[i][1] == sync_q[i][2])
          line[i] <= sync_q[i][2];
      end
    end
  end

  assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr         = req & wb_we_i & wb_sel_i[0];
  assign rd         = req & ~wb_we_i;
  assign en         = c1.port_enable;
  assign master_hw  = c1.port_mode_select == IPC_MODE_MASTER;
  assign slave_mode = c1.port_mode_select inside
    {IPC_MODE_SLV7, IPC_MODE_SLV10, IPC_MODE_SLV7_SS, IPC_MODE_SLV10_SS};
  assign port_busy  = (ms == MS_TX) | (|c2[4:0]);
  assign buf_blocked = (master_hw & port_busy)
    | (slave_mode & s_tx & s_addressed & c1.clock_release);
  assign scl_rise   = line[0] & ~scl_prev;
  assign scl_fall   = ~line[0] & scl_prev;
  assign start_ev   = scl_prev & line[0] & sda_prev & ~line[1];
  assign stop_ev    = scl_prev & line[0] & ~sda_prev & line[1];
  assign match      = serial_shifter[7:1] == address_reload[7:1];
  assign tick       = m_baud == address_reload[6:0];
  assign is_bit     = ms inside {MS_TX, MS_RX, MS_ACK};
  assign last_bit   = (ms == MS_TX) ? IPC_BIT_ACK
                    : (ms == MS_RX) ? IPC_BIT_LAST_RX : 4'h0;
  assign tx_idx     = 3'h7 - m_bit[2:0];
  assign bitval     = (ms == MS_ACK) ? ~c2.ack_value_to_send
                    : (ms == MS_TX) & (m_bit < IPC_BIT_ACK) & ~serial_shifter[tx_idx];
  assign m_done     = tick & (ms != MS_IDLE) & (m_phase == 2'h3)
                    & (~is_bit | (m_bit == last_bit));

  always_comb
  begin
    next_st      = st;
    next_c1      = c1;
    next_c2      = c2;
    next_ms      = ms;
    next_buf     = serial_buffer;
    next_reload  = address_reload;
    next_shift   = serial_shifter;
    next_irq     = port_interrupt_flag;
    next_phase   = m_phase;
    next_bit     = m_bit;
    next_baud    = m_baud;
    next_mscl    = m_scl_low;
    next_msda    = m_sda_low;
    next_sbits   = s_bits;
    next_saddr   = s_addressed;
    next_saddrph = s_addr_phase;
    next_stx     = s_tx;
    next_sackp   = s_ack_pend;
    next_ssda    = s_sda_low;
    next_ack     = req;
    next_dat     = 32'h0000_0000;
    trig         = wb_dat_i[4:0] & (~wb_dat_i[4:0] + 5'h01);
    if (rd)
    begin
      case (wb_adr_i)
        IPC_OFF_STATUS: next_dat[7:0] = st;
        IPC_OFF_CTRL1:  next_dat[7:0] = c1;
        IPC_OFF_CTRL2:  next_dat[7:0] = c2;
        IPC_OFF_BUF:
        begin
          next_dat[7:0] = serial_buffer;
          next_st.buffer_loaded = 1'b0;
        end
        IPC_OFF_RELOAD: next_dat[7:0] = address_reload;
        IPC_OFF_EVENT:  next_dat[0] = port_interrupt_flag;
        default:        next_dat = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      case (wb_adr_i)
        IPC_OFF_STATUS: next_st[7:6] = wb_dat_i[7:6];
        IPC_OFF_CTRL1:  next_c1 = wb_dat_i[7:0];
        IPC_OFF_CTRL2:
        begin
          next_c2[7:5] = wb_dat_i[7:5];
          if (!port_busy)
            next_c2[4:0] = trig;
        end
        IPC_OFF_BUF:
        begin
          if (buf_blocked)
            next_c1.write_clash_flag = 1'b1;
          else
          begin
            next_buf   = wb_dat_i[7:0];
            next_shift = wb_dat_i[7:0];
            next_st.buffer_loaded = 1'b1;
            if (master_hw && en)
            begin
              next_ms    = MS_TX;
              next_phase = 2'h0;
              next_bit   = 4'h0;
              next_baud  = 7'h00;
            end
          end
        end
        IPC_OFF_RELOAD: next_reload = wb_dat_i[7:0];
        IPC_OFF_EVENT:  next_irq = port_interrupt_flag & wb_dat_i[0];
        default:        next_irq = next_irq;
      endcase
    end

    // Master sequence launch
    if ((ms == MS_IDLE) && master_hw && en)
    begin
      next_phase = 2'h0;
      next_bit   = 4'h0;
      next_baud  = 7'h00;
      if (c2.begin_cond_trigger)
        next_ms = MS_START;
      else if (c2.restart_trigger)
        next_ms = MS_RESTART;
      else if (c2.stop_cond_trigger)
        next_ms = MS_STOP;
      else if (c2.receive_trigger)
        next_ms = MS_RX;
      else if (c2.ack_sequence_trigger)
        next_ms = MS_ACK;
    end

    // Master quarter-bit sequencer
    if (ms != MS_IDLE)
    begin
      next_baud = tick ? 7'h00 : m_baud + 7'h01;
      if (tick)
      begin
        next_phase = m_phase + 2'h1;
        case (m_phase)
          2'h0:
          begin
            next_mscl = ms != MS_START;
            next_msda = (ms == MS_STOP) | (is_bit & bitval);
          end
          2'h1:
          begin
            if (ms == MS_START)
              next_msda = 1'b1;
            else
              next_mscl = 1'b0;
          end
          2'h2:
          begin
            if (ms == MS_START)
              next_mscl = 1'b1;
            else if (!line[0])
              next_phase = m_phase;
            else if (ms == MS_RESTART)
              next_msda = 1'b1;
            else if (ms == MS_STOP)
              next_msda = 1'b0;
            else if ((ms == MS_TX) && (m_bit == IPC_BIT_ACK))
              next_c2.peer_ack_flag = line[1];
            else if (ms == MS_RX)
              next_shift = {serial_shifter[6:0], line[1]};
          end
          default:
          begin
            next_mscl = ms != MS_STOP;
            if (is_bit)
              next_bit = m_bit + 4'h1;
            if ((ms == MS_TX) && (m_bit == IPC_BIT_LAST_RX))
              next_st.buffer_loaded = 1'b0;
          end
        endcase
      end
      if (m_done)
      begin
        next_ms  = MS_IDLE;
        next_irq = 1'b1;
        case (ms)
          MS_START:   next_c2.begin_cond_trigger = 1'b0;
          MS_RESTART: next_c2.restart_trigger = 1'b0;
          MS_STOP:    next_c2.stop_cond_trigger = 1'b0;
          MS_ACK:     next_c2.ack_sequence_trigger = 1'b0;
          MS_RX:
          begin
            next_c2.receive_trigger = 1'b0;
            if (st.buffer_loaded)
              next_c1.receive_overrun_flag = 1'b1;
            else
            begin
              next_buf = next_shift;
              next_st.buffer_loaded = 1'b1;
            end
          end
          default: next_ms = MS_IDLE;
        endcase
      end
    end

    // Slave receive, address match and transmit
    if (slave_mode && en)
    begin
      if (start_ev || stop_ev)
      begin
        next_sbits   = 4'h0;
        next_saddrph = start_ev;
        next_saddr   = 1'b0;
        next_stx     = 1'b0;
        next_sackp   = 1'b0;
        next_st.read_dir = 1'b0;
        if (c1.port_mode_select[3])
          next_irq = 1'b1;
      end
      else if (scl_rise && (s_addr_phase || s_addressed))
      begin
        if ((s_bits < IPC_BIT_ACK) && !s_tx)
          next_shift = {serial_shifter[6:0], line[1]};
        if ((s_bits == IPC_BIT_ACK) && s_tx && line[1])
        begin
          next_saddr = 1'b0;
          next_stx   = 1'b0;
          next_st.read_dir = 1'b0;
        end
        next_sbits = s_bits + 4'h1;
      end
      else if (scl_fall && (s_bits == IPC_BIT_ACK) && !s_tx)
      begin
        next_saddrph = 1'b0;
        if (s_addr_phase || s_addressed)
          next_irq = 1'b1;
        if (s_addr_phase && match && !st.buffer_loaded && !c1.receive_overrun_flag)
        begin
          next_saddr = 1'b1;
          next_sackp = 1'b1;
          next_buf   = serial_shifter;
          next_st.buffer_loaded = 1'b1;
          next_st.data_not_addr = 1'b0;
          next_st.read_dir = serial_shifter[0];
          next_st.renew_addr_flag = c1.port_mode_select[0];
        end
        else if (s_addressed && !s_addr_phase)
        begin
          if (st.buffer_loaded)
            next_c1.receive_overrun_flag = 1'b1;
          else if (!c1.receive_overrun_flag)
          begin
            next_sackp = 1'b1;
            next_buf   = serial_shifter;
            next_st.buffer_loaded = 1'b1;
            next_st.data_not_addr = 1'b1;
          end
        end
      end
      else if (scl_fall && (s_bits == IPC_BIT_ACK) && s_tx)
        next_st.buffer_loaded = 1'b0;
      else if (scl_fall && (s_bits == IPC_BIT_END))
      begin
        next_sbits = 4'h0;
        next_sackp = 1'b0;
        if (s_addressed && st.read_dir)
        begin
          next_stx = 1'b1;
          next_c1.clock_release = 1'b0;
          next_st.data_not_addr = s_tx;
          next_irq = 1'b1;
        end
      end
      if (!line[0])
        next_ssda = (s_tx && s_addressed && (s_bits < IPC_BIT_ACK))
          ? ~serial_shifter[3'h7 - s_bits[2:0]] : s_ack_pend;
    end
    else
    begin
      next_sbits   = 4'h0;
      next_saddr   = 1'b0;
      next_saddrph = 1'b0;
      next_stx     = 1'b0;
      next_sackp   = 1'b0;
      next_ssda    = 1'b0;
    end

    // Bus condition flags
    if (start_ev)
    begin
      next_st.start_seen = 1'b1;
      next_st.stop_seen  = 1'b0;
    end
    if (stop_ev)
    begin
      next_st.stop_seen  = 1'b1;
      next_st.start_seen = 1'b0;
    end
    if (master_hw)
      next_st.read_dir = next_ms == MS_TX;
    if (!en)
    begin
      next_st.start_seen = 1'b0;
      next_st.stop_seen  = 1'b0;
      next_ms   = MS_IDLE;
      next_mscl = 1'b0;
      next_msda = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st <= IPC_REG_RST;
      c1 <= IPC_REG_RST;
      c2 <= IPC_REG_RST;
      ms <= MS_IDLE;
      serial_buffer  <= IPC_REG_RST;
      address_reload <= IPC_REG_RST;
      serial_shifter <= IPC_REG_RST;
      port_interrupt_flag <= 1'b0;
      m_phase      <= 2'h0;
      m_bit        <= 4'h0;
      m_baud       <= 7'h00;
      m_scl_low    <= 1'b0;
      m_sda_low    <= 1'b0;
      s_bits       <= 4'h0;
      s_addressed  <= 1'b0;
      s_addr_phase <= 1'b0;
      s_tx         <= 1'b0;
      s_ack_pend   <= 1'b0;
      s_sda_low    <= 1'b0;
      scl_prev     <= 1'b1;
      sda_prev     <= 1'b1;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      scl_oe       <= 1'b0;
      sda_oe       <= 1'b0;
      pins_to_port <= 1'b0;
      slew_control_off <= 1'b0;
      smbus_levels <= 1'b0;
    end
    else
    begin
      st <= next_st;
      c1 <= next_c1;
      c2 <= next_c2;
      ms <= next_ms;
      serial_buffer  <= next_buf;
      address_reload <= next_reload;
      serial_shifter <= next_shift;
      port_interrupt_flag <= next_irq;
      m_phase      <= next_phase;
      m_bit        <= next_bit;
      m_baud       <= next_baud;
      m_scl_low    <= next_mscl;
      m_sda_low    <= next_msda;
      s_bits       <= next_sbits;
      s_addressed  <= next_saddr;
      s_addr_phase <= next_saddrph;
      s_tx         <= next_stx;
      s_ack_pend   <= next_sackp;
      s_sda_low    <= next_ssda;
      scl_prev     <= line[0];
      sda_prev     <= line[1];
      wb_ack_o     <= next_ack;
      wb_dat_o     <= next_dat;
      scl_oe       <= next_c1.port_enable & ((master_hw & next_mscl)
                    | (slave_mode & ~next_c1.clock_release));
      sda_oe       <= next_c1.port_enable & ((master_hw & next_msda)
                    | (slave_mode & next_ssda));
      pins_to_port <= next_c1.port_enable;
      slew_control_off <= next_st.slew_control_off;
      smbus_levels <= next_st.smbus_select;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge core_clk)
  begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_SLEW_OUT: assert property (wr && wb_adr_i == IPC_OFF_STATUS
    |=> slew_control_off == $past(wb_dat_i[7]))
    else $error("slew output does not follow status write");
  AST_SMBUS_OUT: assert property (wr && wb_adr_i == IPC_OFF_STATUS
    |=> smbus_levels == $past(wb_dat_i[6]))
    else $error("smbus output does not follow status write");
  AST_START_FLAG: assert property (en && start_ev
    |=> st.start_seen && !st.stop_seen)
    else $error("start flag not set after start condition");
  AST_FLAGS_OFF: assert property (!en |=> !st.start_seen && !st.stop_seen)
    else $error("condition flags set while port disabled");
  AST_CLASH: assert property (wr && wb_adr_i == IPC_OFF_BUF && buf_blocked
    |=> c1.write_clash_flag && serial_buffer == $past(serial_buffer))
    else $error("blocked buffer write not flagged");
  AST_OVERRUN: assert property (ms == MS_RX && m_done && st.buffer_loaded
    |=> c1.receive_overrun_flag)
    else $error("overrun not flagged");
  AST_SCL_HOLD: assert property (en && slave_mode && !c1.clock_release
    |-> scl_oe)
    else $error("slave clock not held low");
  AST_TRIG_REFUSE: assert property (wr && wb_adr_i == IPC_OFF_CTRL2
    && port_busy |=> (c2[4:0] & ~$past(c2[4:0])) == 5'h00)
    else $error("trigger accepted while busy");
  AST_ONE_TRIG: assert property ($onehot0(c2[4:0]))
    else $error("more than one master trigger pending");
  AST_STOP_CLEAR: assert property (ms == MS_STOP && m_done
    |=> !c2.stop_cond_trigger && ms == MS_IDLE)
    else $error("stop trigger not cleared at sequence end");
  AST_BUF_LOAD: assert property (wr && wb_adr_i == IPC_OFF_BUF && !buf_blocked
    |=> st.buffer_loaded && serial_shifter == $past(wb_dat_i[7:0]))
    else $error("buffer write did not load shifter");

  COV_START_SEQ: cover property (ms == MS_START ##[1:1000] m_done);
  COV_RX_OVERRUN: cover property (ms == MS_RX && m_done && st.buffer_loaded);
  COV_CLASH: cover property (wr && wb_adr_i == IPC_OFF_BUF && buf_blocked);
  COV_SLAVE_MATCH: cover property (scl_fall && s_addr_phase && s_bits == IPC_BIT_ACK && match);
endmodule
`default_nettype wire

/* ipc_slave_model.sv */
`default_nettype none
module ipc_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  input  wire logic       rd_mode,
  input  wire logic [7:0] tx_byte,
  output logic            sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int rcnt = 0;
  // Start or restart: byte count begins again
  always @(negedge sda)
    if (scl === 1'b1)
      cnt = -1;
  // Clock falls: ack slot after the eighth, read bits wrap every nine
  always @(negedge scl)
  begin
    cnt = (cnt == 8) ? 0 : cnt + 1;
    if (rd_mode)
      rcnt = (rcnt == 8) ? 0 : rcnt + 1;
  end
  assign sda_pull = rd_mode ? (rcnt < 8 && tx_byte[7 - rcnt] == 1'b0) : (cnt == 8 && !nack);
endmodule
`default_nettype wire

/* ipc_port_tb_top.sv */
`default_nettype none
module ipc_port_tb_top;
  import ipc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, scl_o, scl_oe, sda_o, sda_oe, sda_pull;
  logic        pins_to_port, slew_control_off, smbus_levels, port_interrupt_flag;
  logic        nack = 1'b0;
  logic        rd_mode = 1'b0;
  logic        m_scl = 1'b0;
  logic        m_sda = 1'b0;
  int          n_mismatch = 0;
  int          tests_run = 0;
  wire logic   scl = ~(scl_oe | m_scl);
  wire logic   sda = ~(sda_oe | sda_pull | m_sda);

  always #5 core_clk = ~core_clk;

  ipc_port #(.ADR_W(8)) ipc_port_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .pins_to_port(pins_to_port),
    .slew_control_off(slew_control_off), .smbus_levels(smbus_levels),
    .port_interrupt_flag(port_interrupt_flag));

  ipc_slave_model ipc_slave_model_i (.scl(scl), .sda(sda), .nack(nack), .rd_mode(rd_mode),
    .tx_byte(8'h3C), .sda_pull(sda_pull));

  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
    if (wb_ack_o !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q & m, e);
  endtask

  task automatic wait_clr(input logic [7:0] a, input logic [7:0] m);
    logic [7:0] q;
    int n;
    n = 0;
    q = m;
    while ((q & m) !== 8'h00 && n < 400)
    begin
      bus(1'b0, a, 8'h00, q);
      n++;
    end
    check(q & m, 8'h00);
    if ((q & m) !== 8'h00)
      finish_test();
  endtask

  task automatic t_reset();
    logic [3:0] modes [6] = '{4'hF, 4'hE, 4'hB, 4'h8, 4'h7, 4'h6};
    rdc(IPC_OFF_STATUS, 8'hFF, IPC_REG_RST);
    rdc(IPC_OFF_CTRL1, 8'hFF, IPC_REG_RST);
    rdc(IPC_OFF_CTRL2, 8'hFF, IPC_REG_RST);
    rdc(8'h18, 8'hFF, 8'h00);
    foreach (modes[i])
    begin
      wr(IPC_OFF_CTRL1, {4'h0, modes[i]});
      rdc(IPC_OFF_CTRL1, 8'hFF, {4'h0, modes[i]});
    end
    wr(IPC_OFF_STATUS, 8'hFF);
    rdc(IPC_OFF_STATUS, 8'hFF, 8'hC0);
    check({6'h0, slew_control_off, smbus_levels}, 8'h03);
    wr(IPC_OFF_STATUS, 8'h00);
    rdc(IPC_OFF_STATUS, 8'hFF, 8'h00);
    check({6'h0, slew_control_off, smbus_levels}, 8'h00);
  endtask

  task automatic t_start();
    wr(IPC_OFF_RELOAD, 8'h03);
    wr(IPC_OFF_CTRL1, {4'h2, IPC_MODE_MASTER});
    wr(IPC_OFF_CTRL2, 8'h01);
    wr(IPC_OFF_CTRL2, 8'h04);
    rdc(IPC_OFF_CTRL2, 8'h1F, 8'h01);
    check({7'h0, pins_to_port}, 8'h01);
    wait_clr(IPC_OFF_CTRL2, 8'h01);
    rdc(IPC_OFF_STATUS, 8'h18, 8'h08);
    check({7'h0, port_interrupt_flag}, 8'h01);
    wr(IPC_OFF_EVENT, 8'h00);
    rdc(IPC_OFF_EVENT, 8'h01, 8'h00);
  endtask

  task automatic t_tx(input logic nk);
    nack = nk;
    wr(IPC_OFF_BUF, 8'hA5);
    rdc(IPC_OFF_STATUS, 8'h05, 8'h05);
    wr(IPC_OFF_BUF, 8'h5A);
    rdc(IPC_OFF_CTRL1, 8'h80, 8'h80);
    wait_clr(IPC_OFF_STATUS, 8'h04);
    rdc(IPC_OFF_CTRL2, 8'h40, {1'b0, nk, 6'h0});
    rdc(IPC_OFF_CTRL1, 8'hFF, 8'hA8);
    wr(IPC_OFF_CTRL1, 8'h28);
    rdc(IPC_OFF_BUF, 8'hFF, 8'hA5);
  endtask

  task automatic t_rx();
    rd_mode = 1'b1;
    wr(IPC_OFF_CTRL2, 8'h08);
    wait_clr(IPC_OFF_CTRL2, 8'h08);
    rdc(IPC_OFF_STATUS, 8'h01, 8'h01);
    wr(IPC_OFF_CTRL2, 8'h10);
    wait_clr(IPC_OFF_CTRL2, 8'h10);
    wr(IPC_OFF_CTRL2, 8'h08);
    wait_clr(IPC_OFF_CTRL2, 8'h08);
    rdc(IPC_OFF_CTRL1, 8'h40, 8'h40);
    rdc(IPC_OFF_BUF, 8'hFF, 8'h3C);
    rdc(IPC_OFF_STATUS, 8'h01, 8'h00);
    wr(IPC_OFF_CTRL2, 8'h30);
    wait_clr(IPC_OFF_CTRL2, 8'h10);
    rdc(IPC_OFF_CTRL2, 8'h3F, 8'h20);
    rd_mode = 1'b0;
  endtask

  task automatic t_end();
    wr(IPC_OFF_CTRL2, 8'h02);
    wait_clr(IPC_OFF_CTRL2, 8'h02);
    rdc(IPC_OFF_STATUS, 8'h18, 8'h08);
    wr(IPC_OFF_CTRL2, 8'h04);
    wait_clr(IPC_OFF_CTRL2, 8'h04);
    rdc(IPC_OFF_STATUS, 8'h18, 8'h10);
    wr(IPC_OFF_CTRL1, 8'h08);
    rdc(IPC_OFF_STATUS, 8'h18, 8'h00);
    check({7'h0, pins_to_port}, 8'h00);
  endtask

  // Bench acting as bus master: line levels after a pause
  task automatic pins(input logic c, input logic d);
    repeat (12) @(posedge core_clk);
    m_scl <= ~c;
    m_sda <= ~d;
  endtask

  task automatic sbyte(input logic [7:0] b, input logic [7:0] ak);
    logic [8:0] v;
    v = {b, 1'b1};
    for (int i = 8; i >= 0; i--)
    begin
      pins(1'b0, v[i]);
      pins(1'b1, v[i]);
      if (i == 0)
        check({7'h0, sda_oe}, ak);
      pins(1'b0, v[i]);
    end
  endtask

  task automatic t_slave();
    wr(IPC_OFF_RELOAD, 8'hA4);
    wr(IPC_OFF_CTRL1, 8'h37);
    wr(IPC_OFF_EVENT, 8'h00);
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    sbyte(8'hA4, 8'h01);
    rdc(IPC_OFF_STATUS, 8'h3F, 8'h0B);
    rdc(IPC_OFF_EVENT, 8'h01, 8'h01);
    rdc(IPC_OFF_BUF, 8'hFF, 8'hA4);
    sbyte(8'h3C, 8'h01);
    rdc(IPC_OFF_STATUS, 8'h21, 8'h21);
    rdc(IPC_OFF_BUF, 8'hFF, 8'h3C);
    pins(1'b0, 1'b0);
    pins(1'b1, 1'b0);
    pins(1'b1, 1'b1);
    pins(1'b1, 1'b1);
    rdc(IPC_OFF_STATUS, 8'h1C, 8'h10);
    wr(IPC_OFF_CTRL1, 8'h27);
    check({7'h0, scl_oe}, 8'h01);
    wr(IPC_OFF_CTRL1, 8'h08);
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_start();
    t_tx(1'b0);
    t_tx(1'b1);
    t_rx();
    t_end();
    t_slave();
    finish_test();
  end
endmodule
`default_nettype wire
